// file: hw/fpx_pkg.sv
// Shared types, offsets and helpers of the floating-point exception detector.
// Assumes one core clock and a register port with 32-bit data words.
//
// Operation
// RL1: Invalid trap always on; destination left undefined.
// RL2: Legacy nonfinite operand raises invalid, except sign-copy.
// RL3: IEEE NaN, infinity or denormal raises invalid.
// RL4: IEEE zero over zero: invalid, not divide-by-zero.
// RL5: Invalid sets its flag and traps issue unit.
// RL6: Divide-by-zero always traps; legacy valid over zero.
// RL7: IEEE divide-by-zero needs valid nonzero numerator.
// RL8: Overflow always traps, float destinations only.
// RL9: Underflow forces destination to 64 zero bits.
// RL10: Underflow flag always set; trap only if enabled.
// RL11: Inexact flag always set; trap only if enabled.
// RL12: Enabled inexact accompanies every overflow and underflow.
// RL13: Enabled inexact also accompanies integer overflow.
// RL14: Inexact trap enable implies overflow, underflow enables.
// RL15: Quad-to-long overflow sets inexact flag, never traps.
// RL16: Integer overflow keeps low bits; traps when enabled.
// RL17: Integer overflow outside signed 64 or 32 range.
// RL18: Software completion always forwarded, never stored.
// RL19: Input exceptions suppress simultaneous output exceptions.
// RL20: Flags sticky until software writes them clear.
package fpx_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses) and field layout
    localparam int FPX_ADDR_W = 4;
    localparam logic [3:0] FPX_OFF_FLAGS = 4'h0;
    localparam logic [3:0] FPX_OFF_ALLOW = 4'h4;
    localparam logic [3:0] FPX_OFF_LAST = 4'h8;
    localparam logic [3:0] FPX_OFF_COUNT = 4'hC;
    localparam int FPX_NFLAG = 6;
    localparam int FPX_BIT_BAD = 0;
    localparam int FPX_BIT_DZ = 1;
    localparam int FPX_BIT_OVF = 2;
    localparam int FPX_BIT_UFL = 3;
    localparam int FPX_BIT_INX = 4;
    localparam int FPX_BIT_IOF = 5;
    localparam int FPX_ALLOW_UFL = 0;
    localparam int FPX_ALLOW_INX = 1;
    localparam int FPX_ALLOW_IOF = 2;
    localparam logic [5:0] FPX_FLAGS_RST = 6'h00;
    localparam logic [2:0] FPX_ALLOW_RST = 3'h7;
    localparam logic [15:0] FPX_COUNT_RST = 16'h0000;
    localparam logic [31:0] FPX_UNMAPPED_RD = 32'h00000000;
    localparam logic [6:0] FPX_QUAD_W = 7'h40;
    localparam logic [6:0] FPX_LONG_W = 7'h20;

    ////////////////////////////////////////////////////////////////////////////////
    // Operation formats, kinds and operand classes
    typedef enum logic {FPX_FMT_LEGACY = 1'b0, FPX_FMT_IEEE = 1'b1} fpx_fmt_e;
    typedef enum logic [2:0] {
        FPX_OP_ARITH = 3'h0, FPX_OP_DIVIDE = 3'h1, FPX_OP_SIGN_COPY = 3'h2,
        FPX_OP_COMPARE = 3'h3, FPX_OP_CVT_F2Q = 3'h4, FPX_OP_CVT_Q2L = 3'h5,
        FPX_OP_CVT_FLT = 3'h6
    } fpx_kind_e;
    typedef enum logic [2:0] {
        FPX_CL_UNUSED = 3'h0, FPX_CL_ZERO = 3'h1, FPX_CL_FINITE = 3'h2, FPX_CL_NAN = 3'h3,
        FPX_CL_INF = 3'h4, FPX_CL_DENORM = 3'h5, FPX_CL_RESERVED = 3'h6,
        FPX_CL_DIRTY_ZERO = 3'h7
    } fpx_class_e;

    // One operation as the datapath reports it at its write-back stage
    typedef struct packed {
        logic valid;
        fpx_fmt_e fmt;
        fpx_kind_e kind;
        fpx_class_e class_a;
        fpx_class_e class_b;
        logic res_ovf;
        logic res_ufl;
        logic res_inexact;
        logic [63:0] result;
        logic [71:0] int_wide;
        logic int_huge;
        logic en_ufl;
        logic en_inx;
        logic en_iof;
        logic cpl;
    } fpx_op_s;

    // Answer to the issue unit, one per operation
    typedef struct packed {
        logic valid;
        logic [5:0] exc;
        logic [5:0] trap;
        logic cpl;
        logic dest_undef;
        logic [63:0] dest;
    } fpx_trap_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers used by more than one check
    function automatic logic fpx_ieee_bad(input fpx_class_e c);
        return (c == FPX_CL_NAN) || (c == FPX_CL_INF) || (c == FPX_CL_DENORM);
    endfunction

    function automatic logic fpx_legacy_bad(input fpx_class_e c);
        return (c == FPX_CL_RESERVED) || (c == FPX_CL_DIRTY_ZERO);
    endfunction

    // True when v sign-extends from its low w bits
    function automatic logic fpx_fits(input logic [71:0] v, input logic [6:0] w);
        logic signed [71:0] s;
        logic [6:0] sh;
        sh = 7'(7'd72 - w);
        s = ($signed(v) <<< sh) >>> sh;
        return s == $signed(v);
    endfunction

endpackage

// file: hw/fpx_detect.sv
// Raw exception conditions of one operation, before priority and enables.
// Assumes the datapath classifies operands and reports rounding outcomes.
`timescale 1ns/1ps
module fpx_detect (
    // Operation under check
    input fpx_pkg::fpx_op_s op,
    // Raw conditions
    output logic [fpx_pkg::FPX_NFLAG-1:0] raw_exc,
    output logic q2l_ovf
);
    import fpx_pkg::*;

    // Operand qualification; sign-copy style ops never take exceptions
    wire can_except = op.valid && (op.kind != FPX_OP_SIGN_COPY);
    wire is_ieee = op.fmt == FPX_FMT_IEEE;
    wire is_div = op.kind == FPX_OP_DIVIDE;
    wire bad_a = is_ieee ? fpx_ieee_bad(op.class_a) : fpx_legacy_bad(op.class_a); // RL2 RL3
    wire bad_b = is_ieee ? fpx_ieee_bad(op.class_b) : fpx_legacy_bad(op.class_b); // RL2 RL3
    wire a_zero = op.class_a == FPX_CL_ZERO;
    wire b_zero = op.class_b == FPX_CL_ZERO;
    wire a_valid = !bad_a && (op.class_a != FPX_CL_UNUSED);
    wire zero_by_zero = is_ieee && is_div && a_zero && b_zero; // RL4
    wire float_dest = (op.kind != FPX_OP_CVT_F2Q) && (op.kind != FPX_OP_CVT_Q2L);

    // Divide by zero differs by format: legacy accepts a zero numerator
    wire dz_num_ok = is_ieee ? (a_valid && !a_zero) : a_valid; // RL6 RL7

    // Integer range checks on the true result
    wire f2q_ovf = op.int_huge || !fpx_fits(op.int_wide, FPX_QUAD_W); // RL17
    wire q2l_range = !fpx_fits(op.int_wide, FPX_LONG_W); // RL17

    assign raw_exc[FPX_BIT_BAD] = can_except && (bad_a || bad_b || zero_by_zero); // RL2 RL3 RL4
    assign raw_exc[FPX_BIT_DZ] = can_except && is_div && b_zero && dz_num_ok; // RL6 RL7
    assign raw_exc[FPX_BIT_OVF] = can_except && op.res_ovf && float_dest; // RL8
    assign raw_exc[FPX_BIT_UFL] = can_except && op.res_ufl && float_dest; // RL10
    assign raw_exc[FPX_BIT_INX] = can_except && op.res_inexact; // RL11
    assign q2l_ovf = can_except && (op.kind == FPX_OP_CVT_Q2L) && q2l_range;
    assign raw_exc[FPX_BIT_IOF] = q2l_ovf
        || (can_except && (op.kind == FPX_OP_CVT_F2Q) && f2q_ovf); // RL17

endmodule

// file: hw/fpx_sticky.sv
// Sticky exception flags with clear-by-write.
// Assumes set and clear arrive as single-cycle vectors in the core clock.
`timescale 1ns/1ps
module fpx_sticky (
    // Clock and reset
    input logic ref_clk,
    input logic rst_b,
    // Set and clear requests
    input logic [fpx_pkg::FPX_NFLAG-1:0] set_vec,
    input logic [fpx_pkg::FPX_NFLAG-1:0] clr_vec,
    // Stored flags
    output logic [fpx_pkg::FPX_NFLAG-1:0] flags
);
    import fpx_pkg::*;

    logic [FPX_NFLAG-1:0] flags_reg;
    logic [FPX_NFLAG-1:0] flags_next;

    // A set in the clearing cycle wins, so no event is lost
    assign flags_next = (flags_reg & ~clr_vec) | set_vec; // RL20
    assign flags = flags_reg;

    // Flag storage
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_reg <= FPX_FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

endmodule

// file: hw/fpx_exception_detect.sv
// Floating-point exception detection, recording and trap reporting.
// Assumes the datapath presents one finished operation per valid cycle and
// that the issue unit consumes the registered answer in the next cycle.
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module fpx_exception_detect (
    // Clock and reset
    input logic ref_clk,
    input logic rst_b,
    // Operation from the datapath
    input fpx_pkg::fpx_op_s op_in,
    // Answer to the issue unit
    output fpx_pkg::fpx_trap_s trap_out,
    // Avalon-MM register slave
    input logic [fpx_pkg::FPX_ADDR_W-1:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    input logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import fpx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [FPX_NFLAG-1:0] raw_exc;
    logic q2l_ovf;
    logic [FPX_NFLAG-1:0] flags;
    logic [FPX_NFLAG-1:0] set_vec;
    logic [FPX_NFLAG-1:0] clr_vec;
    logic [FPX_NFLAG-1:0] rec_exc;
    logic [FPX_NFLAG-1:0] trap_vec;
    logic [63:0] dest_next;
    logic [2:0] allow_reg;
    logic [2:0] allow_next;
    logic [FPX_NFLAG-1:0] last_reg;
    logic [FPX_NFLAG-1:0] last_next;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] rd_data_reg;
    logic [31:0] rd_data_next;
    logic [31:0] rd_mux;
    fpx_trap_s trap_reg;
    fpx_trap_s trap_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Raw detection and sticky flag storage
    fpx_detect u_detect (
        .op(op_in),
        .raw_exc(raw_exc),
        .q2l_ovf(q2l_ovf)
    );

    fpx_sticky u_sticky (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .set_vec(set_vec),
        .clr_vec(clr_vec),
        .flags(flags)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Trap enables as decoded, narrowed by the software allow mask
    wire is_q2l = op_in.kind == FPX_OP_CVT_Q2L;
    wire is_f2q = op_in.kind == FPX_OP_CVT_F2Q;
    // No quad-to-long variant enables inexact, so its enable is ignored
    wire en_inx = op_in.en_inx && !is_q2l && allow_reg[FPX_ALLOW_INX]; // RL15
    // Every variant enabling inexact also enables underflow
    wire en_ufl = (op_in.en_ufl || op_in.en_inx) && allow_reg[FPX_ALLOW_UFL]; // RL14
    wire en_iof = op_in.en_iof && allow_reg[FPX_ALLOW_IOF]; // RL16

    ////////////////////////////////////////////////////////////////////////////////
    // Priority: any operand exception hides every result exception
    wire in_exc = raw_exc[FPX_BIT_BAD] || raw_exc[FPX_BIT_DZ]; // RL19
    wire out_ovf = raw_exc[FPX_BIT_OVF] && !in_exc; // RL19
    wire out_ufl = raw_exc[FPX_BIT_UFL] && !in_exc; // RL19
    wire out_iof = raw_exc[FPX_BIT_IOF] && !in_exc; // RL19
    // Inexact joins overflow, underflow and integer overflow when enabled
    wire inx_joined = en_inx && (out_ovf || out_ufl || out_iof); // RL12 RL13
    // Quad-to-long overflow records inexact without an inexact trap
    wire inx_q2l = q2l_ovf && !in_exc; // RL15
    wire out_inx = !in_exc && (raw_exc[FPX_BIT_INX] || inx_joined || inx_q2l); // RL11

    // Recorded exceptions
    assign rec_exc[FPX_BIT_BAD] = raw_exc[FPX_BIT_BAD]; // RL5
    assign rec_exc[FPX_BIT_DZ] = raw_exc[FPX_BIT_DZ]; // RL6
    assign rec_exc[FPX_BIT_OVF] = out_ovf; // RL8
    assign rec_exc[FPX_BIT_UFL] = out_ufl; // RL10
    assign rec_exc[FPX_BIT_INX] = out_inx; // RL11
    assign rec_exc[FPX_BIT_IOF] = out_iof; // RL16

    // Delivered traps: invalid, divide and overflow can never be masked
    assign trap_vec[FPX_BIT_BAD] = rec_exc[FPX_BIT_BAD]; // RL1 RL5
    assign trap_vec[FPX_BIT_DZ] = rec_exc[FPX_BIT_DZ]; // RL6 RL7
    assign trap_vec[FPX_BIT_OVF] = rec_exc[FPX_BIT_OVF]; // RL8
    assign trap_vec[FPX_BIT_UFL] = rec_exc[FPX_BIT_UFL] && en_ufl; // RL10
    assign trap_vec[FPX_BIT_INX] = rec_exc[FPX_BIT_INX] && en_inx; // RL11 RL15
    assign trap_vec[FPX_BIT_IOF] = rec_exc[FPX_BIT_IOF] && en_iof; // RL16

    ////////////////////////////////////////////////////////////////////////////////
    // Destination value
    // Underflow gives a true zero even where a negative zero is proper
    wire [63:0] long_dest = {32'h00000000, op_in.int_wide[31:0]};
    assign dest_next = out_ufl ? 64'h0000000000000000 // RL9
        : is_q2l ? long_dest // RL16
        : is_f2q ? op_in.int_wide[63:0] // RL16
        : op_in.result; // RL11
    // Invalid, divide and overflow leave the destination undefined
    wire dest_undef = rec_exc[FPX_BIT_BAD] || rec_exc[FPX_BIT_DZ] || out_ovf; // RL1 RL8

    // Next answer; software completion goes out on every operation
    always_comb begin
        trap_next = '0;
        trap_next.valid = op_in.valid;
        trap_next.cpl = op_in.valid && op_in.cpl; // RL18
        if (op_in.valid) begin
            trap_next.exc = rec_exc;
            trap_next.trap = trap_vec;
            trap_next.dest_undef = dest_undef;
            trap_next.dest = dest_next;
        end
    end

    // Registered answer to the issue unit
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            trap_reg <= '0;
        end else begin
            trap_reg <= trap_next;
        end
    end
    assign trap_out = trap_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register slave: one wait state, then the access completes
    // The fixed wait lets read data come from a register without a mux in the path
    wire bus_req = avs_read || avs_write;
    wire wr_fire = avs_write && ack_reg;
    wire lane0 = avs_byteenable[0];
    wire sel_flags = avs_address == FPX_OFF_FLAGS;
    wire sel_allow = avs_address == FPX_OFF_ALLOW;
    wire sel_last = avs_address == FPX_OFF_LAST;
    wire sel_count = avs_address == FPX_OFF_COUNT;
    assign ack_next = bus_req && !ack_reg;
    assign avs_waitrequest = bus_req && !ack_reg;

    // Writing a one clears that flag; the software completion bit is not here
    assign clr_vec = (wr_fire && sel_flags && lane0) ? avs_writedata[FPX_NFLAG-1:0] : '0; // RL20
    assign set_vec = op_in.valid ? rec_exc : '0; // RL5 RL18
    assign allow_next = (wr_fire && sel_allow && lane0) ? avs_writedata[2:0] : allow_reg;

    // Last recorded set and a wrapping count of delivered traps
    assign last_next = (op_in.valid && (rec_exc != '0)) ? rec_exc : last_reg;
    assign count_next = (op_in.valid && (trap_vec != '0)) ? 16'(count_reg + 16'h0001)
        : count_reg;

    // Read mux; unmapped addresses read zero
    assign rd_mux = sel_flags ? {26'h0000000, flags}
        : sel_allow ? {29'h00000000, allow_reg}
        : sel_last ? {26'h0000000, last_reg}
        : sel_count ? {16'h0000, count_reg}
        : FPX_UNMAPPED_RD;
    assign rd_data_next = (avs_read && !ack_reg) ? rd_mux : rd_data_reg;
    assign avs_readdata = rd_data_reg;

    // Bus handshake state
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_reg <= 1'b0;
            rd_data_reg <= FPX_UNMAPPED_RD;
        end else begin
            ack_reg <= ack_next;
            rd_data_reg <= rd_data_next;
        end
    end

    // Software-visible control and status
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            allow_reg <= FPX_ALLOW_RST;
            last_reg <= FPX_FLAGS_RST;
            count_reg <= FPX_COUNT_RST;
        end else begin
            allow_reg <= allow_next;
            last_reg <= last_next;
            count_reg <= count_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // Helpers capturing the previous operation
    logic prev_q2l;
    logic prev_sc;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q2l <= 1'b0;
            prev_sc <= 1'b0;
        end else begin
            prev_q2l <= op_in.valid && is_q2l;
            prev_sc <= op_in.valid && (op_in.kind == FPX_OP_SIGN_COPY);
        end
    end

    wire ieee_zz = op_in.valid && (op_in.fmt == FPX_FMT_IEEE) && (op_in.kind == FPX_OP_DIVIDE)
        && (op_in.class_a == FPX_CL_ZERO) && (op_in.class_b == FPX_CL_ZERO);
    wire legacy_dz = op_in.valid && (op_in.fmt == FPX_FMT_LEGACY)
        && (op_in.kind == FPX_OP_DIVIDE) && (op_in.class_a == FPX_CL_FINITE)
        && (op_in.class_b == FPX_CL_ZERO);

    AST_CPL_PASS: assert property ( // RL18
        op_in.valid |=> trap_out.valid && (trap_out.cpl == $past(op_in.cpl)))
        else $error("software completion not forwarded");

    AST_ZERO_OVER_ZERO: assert property ( // RL4
        ieee_zz |=> trap_out.exc[FPX_BIT_BAD] && !trap_out.exc[FPX_BIT_DZ]
            && trap_out.trap[FPX_BIT_BAD])
        else $error("ieee zero over zero not reported as invalid");

    AST_LEGACY_DZ: assert property ( // RL6
        legacy_dz |=> trap_out.trap[FPX_BIT_DZ] && trap_out.dest_undef)
        else $error("legacy divide by zero not trapped");

    AST_UFL_ZERO: assert property ( // RL9
        op_in.valid && op_in.res_ufl && !in_exc && (op_in.kind == FPX_OP_ARITH)
            |=> (trap_out.dest == 64'h0000000000000000) && trap_out.exc[FPX_BIT_UFL])
        else $error("underflow destination not forced to zero");

    AST_IN_PRIORITY: assert property ( // RL19
        trap_out.valid && (trap_out.exc[FPX_BIT_BAD] || trap_out.exc[FPX_BIT_DZ])
            |-> (trap_out.exc[5:2] == 4'h0) && (trap_out.trap[5:2] == 4'h0))
        else $error("output exception reported beside input exception");

    AST_Q2L_NO_INX_TRAP: assert property ( // RL15
        prev_q2l |-> !trap_out.trap[FPX_BIT_INX]
            && (!trap_out.exc[FPX_BIT_IOF] || trap_out.exc[FPX_BIT_INX]))
        else $error("quad to long inexact handling wrong");

    AST_OVF_INX: assert property ( // RL12
        op_in.valid && out_ovf && en_inx
            |=> trap_out.trap[FPX_BIT_OVF] && trap_out.trap[FPX_BIT_INX])
        else $error("inexact missing beside overflow");

    AST_UFL_GATED: assert property ( // RL10
        op_in.valid && out_ufl && !op_in.en_ufl && !op_in.en_inx
            |=> trap_out.exc[FPX_BIT_UFL] && !trap_out.trap[FPX_BIT_UFL])
        else $error("underflow trapped while disabled");

    AST_SIGN_COPY: assert property ( // RL2
        prev_sc |-> (trap_out.exc == '0) && (trap_out.trap == '0))
        else $error("sign copy raised an exception");

    AST_FLAG_STICKY: assert property ( // RL20
        ((flags & ~$past(flags)) == '0) || $past(op_in.valid))
        else $error("flag set without an operation");

    AST_FLAG_HOLD: assert property ( // RL20
        !wr_fire |=> (($past(flags) & ~flags) == '0))
        else $error("sticky flag dropped without a clearing write");

    COV_INVALID: cover property (op_in.valid && raw_exc[FPX_BIT_BAD]);
    COV_UFL_TRAP: cover property (op_in.valid && trap_vec[FPX_BIT_UFL]);
    COV_CLEAR: cover property (wr_fire && sel_flags && (flags != '0));
    COV_Q2L_OVF: cover property (op_in.valid && q2l_ovf);

endmodule

// file: bench/fpx_issue_model.sv
// Issue unit model: consumes trap answers and keeps its own summary state.
// Assumes each answer from the detector stands for exactly one core cycle.
`timescale 1ns/1ps
module fpx_issue_model (
    // Clock and reset
    input logic ref_clk,
    input logic rst_b,
    // Answer from the exception detector
    input fpx_pkg::fpx_trap_s trap_in,
    // Summary state
    output logic cpl_sum_reg,
    output logic [15:0] trap_cnt_reg
);
    import fpx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Completion only marks the summary when it arrives alongside a trap
    logic got_trap;
    assign got_trap = trap_in.valid && (trap_in.trap != 6'h00);

    // Summary stays set until reset; the count wraps like the device's counter
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cpl_sum_reg <= 1'b0;
            trap_cnt_reg <= 16'h0000;
        end else begin
            if (got_trap && trap_in.cpl) cpl_sum_reg <= 1'b1;
            if (got_trap) trap_cnt_reg <= trap_cnt_reg + 16'h0001;
        end
    end
endmodule

// file: bench/fp_exception_detect_tb_top.sv
// Self-checking bench: an operation table, register access and two resets.
// Assumes the detector answers one cycle after each operation it takes.
`timescale 1ns/1ps
module fp_exception_detect_tb_top;
    import fpx_pkg::*;
    typedef struct packed {
        fpx_op_s op;
        logic [5:0] exc;
        logic [5:0] trap;
        logic [64:0] ud;
    } fpx_row_s;
    localparam logic [63:0] RES = 64'h3FF0_0000_0000_0001;
    localparam logic [64:0] UND = 65'h1_0000_0000_0000_0000;
    localparam logic [64:0] DRES = {1'b0, RES};
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    fpx_op_s op_in = '0;
    fpx_trap_s trap_out;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic cpl_sum;
    logic [15:0] trap_cnt;
    int error_cnt = 0;
    int n_compared = 0;
    int exp_cnt;
    logic [31:0] rd;
    fpx_row_s rows[$];

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, design and issue unit model
    always #25 ref_clk = ~ref_clk;

    fpx_exception_detect i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .op_in(op_in),
        .trap_out(trap_out), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    fpx_issue_model i_issue (.ref_clk(ref_clk), .rst_b(rst_b), .trap_in(trap_out),
        .cpl_sum_reg(cpl_sum), .trap_cnt_reg(trap_cnt));

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Fields of fl: ovf, ufl, inexact, ufl enable, inexact enable, int enable, completion
    function automatic fpx_row_s mk(input logic [3:0] fk, input logic [5:0] cl,
            input logic [6:0] fl, input logic [71:0] w, input logic [5:0] exc,
            input logic [5:0] trap, input logic [64:0] ud);
        fpx_row_s r;
        r = '0;
        r.op.valid = 1'b1;
        r.op.fmt = fpx_fmt_e'(fk[3]);
        r.op.kind = fpx_kind_e'(fk[2:0]);
        r.op.class_a = fpx_class_e'(cl[5:3]);
        r.op.class_b = fpx_class_e'(cl[2:0]);
        {r.op.res_ovf, r.op.res_ufl, r.op.res_inexact} = fl[6:4];
        {r.op.en_ufl, r.op.en_inx, r.op.en_iof, r.op.cpl} = fl[3:0];
        r.op.result = RES;
        r.op.int_wide = w;
        r.exc = exc;
        r.trap = trap;
        r.ud = ud;
        return r;
    endfunction

    // The answer stands for one cycle only, so it is looked at mid-cycle
    task automatic chk_ans(input fpx_row_s r);
        chk(trap_out.valid, 1'b1);
        chk(trap_out.exc, r.exc);
        chk(trap_out.trap, r.trap);
        chk(trap_out.cpl, r.op.cpl);
        chk(trap_out.dest_undef, r.ud[64]);
        if (!r.ud[64]) chk(trap_out.dest, r.ud[63:0]);
    endtask

    task automatic run_op(input fpx_row_s r);
        @(posedge ref_clk);
        op_in <= r.op;
        @(posedge ref_clk);
        op_in <= '0;
        @(negedge ref_clk);
        chk_ans(r);
    endtask

    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) error_cnt++;
    endtask

    task automatic chk_reg(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk(trap_out.valid, 1'b0);
        chk({cpl_sum, trap_cnt}, 17'h0_0000);
        rst_b <= 1'b1;
        chk_reg(FPX_OFF_FLAGS, 32'h0000_0000);
        chk_reg(FPX_OFF_ALLOW, 32'h0000_0007);
        chk_reg(FPX_OFF_LAST, 32'h0000_0000);
        chk_reg(FPX_OFF_COUNT, 32'h0000_0000);
        chk_reg(4'h6, 32'h0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge ref_clk);
        error_cnt++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        rows = '{mk(4'h8, 6'h1A, 7'h01, 72'h0, 6'h01, 6'h01, UND),
            mk(4'h8, 6'h14, 7'h00, 72'h0, 6'h01, 6'h01, UND),
            mk(4'h8, 6'h2A, 7'h00, 72'h0, 6'h01, 6'h01, UND),
            mk(4'h0, 6'h32, 7'h00, 72'h0, 6'h01, 6'h01, UND),
            mk(4'h0, 6'h17, 7'h00, 72'h0, 6'h01, 6'h01, UND),
            mk(4'h2, 6'h32, 7'h00, 72'h0, 6'h00, 6'h00, DRES),
            mk(4'h9, 6'h09, 7'h00, 72'h0, 6'h01, 6'h01, UND),
            mk(4'h9, 6'h11, 7'h00, 72'h0, 6'h02, 6'h02, UND),
            mk(4'h1, 6'h11, 7'h00, 72'h0, 6'h02, 6'h02, UND),
            mk(4'h8, 6'h12, 7'h40, 72'h0, 6'h04, 6'h04, UND),
            mk(4'h8, 6'h12, 7'h44, 72'h0, 6'h14, 6'h14, UND),
            mk(4'h8, 6'h12, 7'h28, 72'h0, 6'h08, 6'h08, 65'h0),
            mk(4'h8, 6'h12, 7'h20, 72'h0, 6'h08, 6'h00, 65'h0),
            mk(4'h8, 6'h12, 7'h24, 72'h0, 6'h18, 6'h18, 65'h0),
            mk(4'h8, 6'h12, 7'h10, 72'h0, 6'h10, 6'h00, DRES),
            mk(4'h8, 6'h12, 7'h14, 72'h0, 6'h10, 6'h10, DRES),
            mk(4'hC, 6'h10, 7'h02, 72'h00_8000_0000_0000_0000, 6'h20, 6'h20,
                65'h0_8000_0000_0000_0000),
            mk(4'hC, 6'h10, 7'h06, 72'hFF_7FFF_FFFF_FFFF_FFFF, 6'h30, 6'h30,
                65'h0_7FFF_FFFF_FFFF_FFFF),
            mk(4'hC, 6'h10, 7'h02, 72'hFF_8000_0000_0000_0000, 6'h00, 6'h00,
                65'h0_8000_0000_0000_0000),
            mk(4'hD, 6'h10, 7'h02, 72'h00_0000_0000_8000_0000, 6'h30, 6'h20,
                65'h0_0000_0000_8000_0000),
            mk(4'hD, 6'h10, 7'h00, 72'hFF_FFFF_FFFF_7FFF_FFFF, 6'h30, 6'h00,
                65'h0_0000_0000_7FFF_FFFF),
            mk(4'hD, 6'h10, 7'h02, 72'hFF_FFFF_FFFF_8000_0000, 6'h00, 6'h00,
                65'h0_0000_0000_8000_0000),
            mk(4'hC, 6'h10, 7'h40, 72'h0, 6'h00, 6'h00, 65'h0),
            mk(4'h8, 6'h1A, 7'h54, 72'h0, 6'h01, 6'h01, UND)};
        do_reset();
        $display("Test reset done");
        exp_cnt = 0;
        foreach (rows[i]) begin
            run_op(rows[i]);
            if (rows[i].trap != 6'h00) exp_cnt++;
        end
        chk_reg(FPX_OFF_FLAGS, 32'h0000_003F);
        chk(cpl_sum, 1'b1);
        chk(trap_cnt, 16'(exp_cnt));
        chk_reg(FPX_OFF_LAST, 32'h0000_0001);
        chk_reg(FPX_OFF_COUNT, 32'(exp_cnt));
        $display("Test table done");
        // Clearing one flag leaves the others standing
        bus(1'b1, FPX_OFF_FLAGS, 32'h0000_0001);
        chk_reg(FPX_OFF_FLAGS, 32'h0000_003E);
        // With every optional trap masked, invalid must still trap
        bus(1'b1, FPX_OFF_ALLOW, 32'h0000_0000);
        run_op(mk(4'h8, 6'h12, 7'h14, 72'h0, 6'h10, 6'h00, DRES));
        run_op(rows[0]);
        bus(1'b1, FPX_OFF_ALLOW, 32'h0000_0007);
        chk_reg(FPX_OFF_FLAGS, 32'h0000_003F);
        $display("Test mask done");
        // Back to back operations, each answered in its own cycle
        @(posedge ref_clk);
        op_in <= rows[10].op;
        @(posedge ref_clk);
        op_in <= rows[11].op;
        @(negedge ref_clk);
        chk_ans(rows[10]);
        @(posedge ref_clk);
        op_in <= '0;
        @(negedge ref_clk);
        chk_ans(rows[11]);
        $display("Test back to back done");
        do_reset();
        $display("Test second reset done");
        report_and_stop();
    end
endmodule
